//--- cascaded_interval_counter.sv
// The APB register port and the placing of the registers were decided locally.
`default_nettype none
module cascaded_interval_counter
	import interval_counter_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// external io connector
	input wire logic ext_clk,
	input wire logic ext_gate,
	output logic ext_out,
	// interrupt
	output logic irq
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] acc;
		logic tick4;
		logic [1:0] route;
		logic [2:0] gate_sw;
		logic [1:0] status;
		logic [1:0] mask;
		logic irq;
		logic [2:0] out_prev;
		logic [2:0] gate_prev;
		logic clk_s1;
		logic clk_s2;
		logic clk_s3;
		logic gate_s1;
		logic gate_s2;
		logic ext_out;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} top_state_type;

	top_state_type r_reg;
	top_state_type r_next;

	counter_link_if link[3] ();

	logic [2:0] ch_out;
	logic [2:0] ch_tc;
	logic [15:0] ch_count [3];
	logic [2:0] ch_tick;
	logic [2:0] ch_gate;
	logic [2:0] ch_load;
	logic [2:0] ch_mode_wr;
	logic wr_en;
	logic rd_en;
	logic ext_route;
	logic ext_clk_rise;

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	function automatic logic [2:0] chan_hit(input logic [7:0] addr,
		input logic [7:0] base);
		logic [2:0] hit;
		hit = 3'h0;
		for (int i = 0; i < 3; i++)
			if (addr == base + 8'(4 * i))
				hit[i] = 1'b1;
		return hit;
	endfunction

	function automatic logic is_mapped(input logic [7:0] addr);
		logic m;
		m = (|chan_hit(addr, MODE_BASE)) || (|chan_hit(addr, COUNT_BASE));
		m = m || addr == CONFIG_OFFSET || addr == STATUS_OFFSET;
		m = m || addr == INT_MASK_OFFSET || addr == OUT_STATE_OFFSET;
		return m;
	endfunction

	assign wr_en = psel && penable && r_reg.pready && pwrite;
	assign rd_en = psel && penable && r_reg.pready && !pwrite;
	assign ch_load = wr_en ? chan_hit(paddr, COUNT_BASE) : 3'h0;
	assign ch_mode_wr = wr_en ? chan_hit(paddr, MODE_BASE) : 3'h0;

	// ----------------------------------------------------------------
	// routing of clocks and gates
	// ----------------------------------------------------------------
	assign ext_route = (r_reg.route == ROUTE_EXT_FULL) ||
		(r_reg.route == ROUTE_EXT_GATE);
	assign ext_clk_rise = r_reg.clk_s2 && !r_reg.clk_s3;

	always_comb
	begin
		ch_tick[0] = r_reg.tick4;
		ch_tick[2] = ch_out[1] && !r_reg.out_prev[1];
		if (r_reg.route == ROUTE_EXT_FULL)
			ch_tick[1] = ext_clk_rise;
		else
			ch_tick[1] = ch_out[0] && !r_reg.out_prev[0];
		ch_gate[0] = r_reg.gate_sw[0];
		if (ext_route)
			ch_gate[2:1] = {2{r_reg.gate_s2}};
		else
			ch_gate[2:1] = r_reg.gate_sw[2:1];
	end

	// ----------------------------------------------------------------
	// counter channels
	// ----------------------------------------------------------------
	generate
		for (genvar g = 0; g < 3; g++)
		begin : g_chan
			assign link[g].tick = ch_tick[g];
			assign link[g].gate = ch_gate[g];
			assign link[g].gate_rise = ch_gate[g] && !r_reg.gate_prev[g];
			assign link[g].load = ch_load[g];
			assign link[g].mode_wr = ch_mode_wr[g];
			assign link[g].wdata = pwdata[15:0];
			assign ch_out[g] = link[g].out;
			assign ch_tc[g] = link[g].tc;
			assign ch_count[g] = link[g].count;
			counter_channel u_chan (
				.pclk(pclk),
				.presetn(presetn),
				.link(link[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		logic [7:0] sum;
		logic [1:0] clr;
		logic [1:0] set;
		logic [2:0] rhit;
		sum = 8'h00;
		clr = 2'h0;
		set = 2'h0;
		rhit = 3'h0;
		r_next = r_reg;
		sum = r_reg.acc + TICK_STEP;
		if (sum >= TICK_MOD)
		begin
			r_next.acc = sum - TICK_MOD;
			r_next.tick4 = 1'b1;
		end
		else
		begin
			r_next.acc = sum;
			r_next.tick4 = 1'b0;
		end
		r_next.clk_s1 = ext_clk;
		r_next.clk_s2 = r_reg.clk_s1;
		r_next.clk_s3 = r_reg.clk_s2;
		r_next.gate_s1 = ext_gate;
		r_next.gate_s2 = r_reg.gate_s1;
		r_next.out_prev = ch_out;
		r_next.gate_prev = ch_gate;
		r_next.ext_out = ext_route ? ch_out[2] : 1'b0;
		if (wr_en && paddr == CONFIG_OFFSET)
		begin
			r_next.route = pwdata[ROUTE_LSB +: 2];
			r_next.gate_sw = pwdata[GATE_LSB +: 3];
		end
		if (wr_en && paddr == INT_MASK_OFFSET)
			r_next.mask = pwdata[1:0];
		if (rd_en && paddr == STATUS_OFFSET)
			clr = 2'h3;
		set[STAT_COUNTUP] = ch_tc[2];
		set[STAT_OVERRUN] = ch_tc[2] && r_reg.status[STAT_COUNTUP] &&
			!clr[STAT_COUNTUP];
		r_next.status = (r_reg.status & ~clr) | set;
		r_next.irq = |(r_reg.status & r_reg.mask);
		// apb: answer in the first access cycle
		r_next.pready = psel && !penable;
		r_next.pslverr = 1'b0;
		r_next.prdata = 32'h0000_0000;
		if (psel && !penable)
		begin
			r_next.pslverr = !is_mapped(paddr);
			rhit = chan_hit(paddr, COUNT_BASE);
			for (int i = 0; i < 3; i++)
				if (rhit[i])
					r_next.prdata = {16'h0000, ch_count[i]};
			case (paddr)
			CONFIG_OFFSET:
				r_next.prdata = {27'h0, r_reg.gate_sw, r_reg.route};
			STATUS_OFFSET:
				r_next.prdata = {30'h0, r_reg.status | set};
			INT_MASK_OFFSET:
				r_next.prdata = {30'h0, r_reg.mask};
			OUT_STATE_OFFSET:
				r_next.prdata = {29'h0, ch_out};
			default:
				r_next.prdata = r_next.prdata;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			r_reg <= '{acc: 8'h00, tick4: 1'b0, route: ROUTE_RESET,
				gate_sw: GATE_RESET, status: 2'h0, mask: MASK_RESET,
				irq: 1'b0, out_prev: 3'h0, gate_prev: 3'h0, clk_s1: 1'b0,
				clk_s2: 1'b0, clk_s3: 1'b0, gate_s1: 1'b0, gate_s2: 1'b0,
				ext_out: 1'b0, pready: 1'b0, pslverr: 1'b0,
				prdata: 32'h0000_0000};
		else
			r_reg <= r_next;
	end

	assign prdata = r_reg.prdata;
	assign pready = r_reg.pready;
	assign pslverr = r_reg.pslverr;
	assign ext_out = r_reg.ext_out;
	assign irq = r_reg.irq;
endmodule // cascaded_interval_counter
`default_nettype wire

//--- interval_counter_pkg.sv
`default_nettype none
package interval_counter_pkg;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] MODE_BASE = 8'h00;
	localparam logic [7:0] COUNT_BASE = 8'h10;
	localparam logic [7:0] CONFIG_OFFSET = 8'h20;
	localparam logic [7:0] STATUS_OFFSET = 8'h24;
	localparam logic [7:0] INT_MASK_OFFSET = 8'h28;
	localparam logic [7:0] OUT_STATE_OFFSET = 8'h2c;
	// ----------------------------------------------------------------
	// field layout and reset values
	// ----------------------------------------------------------------
	localparam int ROUTE_LSB = 0;
	localparam int GATE_LSB = 2;
	localparam int STAT_COUNTUP = 0;
	localparam int STAT_OVERRUN = 1;
	localparam logic [1:0] ROUTE_RESET = 2'h0;
	localparam logic [2:0] GATE_RESET = 3'h0;
	localparam logic [1:0] MASK_RESET = 2'h0;
	localparam logic [2:0] MODE_RESET = 3'h0;
	// ----------------------------------------------------------------
	// route selector values
	// ----------------------------------------------------------------
	localparam logic [1:0] ROUTE_CASCADE = 2'h0;
	localparam logic [1:0] ROUTE_EXT_FULL = 2'h1;
	localparam logic [1:0] ROUTE_EXT_GATE = 2'h2;
	// ----------------------------------------------------------------
	// counter modes
	// ----------------------------------------------------------------
	localparam logic [2:0] MODE_TC_EVENT = 3'h0;
	localparam logic [2:0] MODE_ONE_SHOT = 3'h1;
	localparam logic [2:0] MODE_RATE = 3'h2;
	localparam logic [2:0] MODE_SQUARE = 3'h3;
	// ----------------------------------------------------------------
	// timing: 4 MHz count clock from pclk by fractional accumulation
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 125_000_000;
	localparam int TICK_HZ = 4_000_000;
	localparam logic [7:0] TICK_MOD = 8'(CLK_HZ / 1_000_000);
	localparam logic [7:0] TICK_STEP = 8'(TICK_HZ / 1_000_000);
endpackage
`default_nettype wire

//--- counter_link_if.sv
`default_nettype none
interface counter_link_if;
	logic tick;
	logic gate;
	logic gate_rise;
	logic load;
	logic mode_wr;
	logic [15:0] wdata;
	logic out;
	logic tc;
	logic [15:0] count;
	modport ctl (output tick, gate, gate_rise, load, mode_wr, wdata,
		input out, tc, count);
	modport chan (input tick, gate, gate_rise, load, mode_wr, wdata,
		output out, tc, count);
endinterface
`default_nettype wire

//--- counter_channel.sv
`default_nettype none
module counter_channel
	import interval_counter_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control side
	counter_link_if.chan link
);
	typedef struct packed {
		logic [15:0] count;
		logic [15:0] reload;
		logic [2:0] mode;
		logic pending;
		logic armed;
		logic running;
		logic trig;
		logic out;
		logic tc;
	} chan_state_type;

	chan_state_type r_reg;
	chan_state_type r_next;
	logic start;

	always_comb
	begin
		r_next = r_reg;
		r_next.tc = 1'b0;
		start = r_reg.trig | link.gate_rise;
		if (link.mode_wr)
		begin
			r_next.mode = link.wdata[2:0];
			r_next.pending = 1'b0;
			r_next.running = 1'b0;
			r_next.trig = 1'b0;
			r_next.out = (link.wdata[2:0] != MODE_TC_EVENT);
		end
		else if (link.load)
		begin
			r_next.reload = link.wdata;
			r_next.pending = 1'b1;
			r_next.armed = 1'b1;
			if (r_reg.mode == MODE_TC_EVENT)
				r_next.out = 1'b0;
		end
		else
		begin
			if (link.gate_rise)
				r_next.trig = 1'b1;
			if (link.tick)
			begin
				case (r_reg.mode)
				MODE_TC_EVENT:
					if (r_reg.pending)
					begin
						r_next.count = r_reg.reload;
						r_next.pending = 1'b0;
						r_next.running = 1'b1;
					end
					else if (link.gate && r_reg.running)
					begin
						r_next.count = r_reg.count - 16'h0001;
						if (r_reg.count == 16'h0001)
						begin
							r_next.out = 1'b1;
							r_next.running = 1'b0;
							r_next.tc = 1'b1;
						end
					end
				MODE_ONE_SHOT:
					if (start && r_reg.armed)
					begin
						r_next.count = r_reg.reload;
						r_next.out = 1'b0;
						r_next.running = 1'b1;
						r_next.trig = 1'b0;
					end
					else if (r_reg.running)
					begin
						r_next.count = r_reg.count - 16'h0001;
						if (r_reg.count == 16'h0001)
						begin
							r_next.out = 1'b1;
							r_next.running = 1'b0;
							r_next.tc = 1'b1;
						end
					end
				MODE_RATE:
					if (r_reg.pending || (start && r_reg.armed))
					begin
						r_next.count = r_reg.reload;
						r_next.pending = 1'b0;
						r_next.trig = 1'b0;
						r_next.running = 1'b1;
						r_next.out = 1'b1;
					end
					else if (link.gate && r_reg.running)
					begin
						if (r_reg.count == 16'h0001)
						begin
							r_next.count = r_reg.reload;
							r_next.out = 1'b1;
						end
						else
						begin
							r_next.count = r_reg.count - 16'h0001;
							if (r_reg.count == 16'h0002)
							begin
								r_next.out = 1'b0;
								r_next.tc = 1'b1;
							end
						end
					end
				MODE_SQUARE:
					if (r_reg.pending || (start && r_reg.armed))
					begin
						r_next.count = r_reg.reload;
						r_next.pending = 1'b0;
						r_next.trig = 1'b0;
						r_next.running = 1'b1;
						r_next.out = 1'b1;
					end
					else if (link.gate && r_reg.running)
					begin
						if (r_reg.count <= 16'h0002)
						begin
							r_next.count = r_reg.reload;
							r_next.out = ~r_reg.out;
							r_next.tc = r_reg.out;
						end
						else
							r_next.count = r_reg.count - 16'h0002;
					end
				default:
					r_next.running = 1'b0;
				endcase
			end
			// periodic modes hold their output high while gated off
			if (!link.gate && (r_reg.mode == MODE_RATE ||
				r_reg.mode == MODE_SQUARE))
				r_next.out = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			r_reg <= '{count: 16'h0000, reload: 16'h0000, mode: MODE_RESET,
				pending: 1'b0, armed: 1'b0, running: 1'b0, trig: 1'b0,
				out: 1'b0, tc: 1'b0};
		else
			r_reg <= r_next;
	end

	assign link.out = r_reg.out;
	assign link.tc = r_reg.tc;
	assign link.count = r_reg.count;
endmodule // counter_channel
`default_nettype wire

//--- counter_sva.sv
`default_nettype none
module counter_sva
	import interval_counter_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// connector and interrupt
	input wire logic ext_clk,
	input wire logic ext_gate,
	input wire logic ext_out,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// ----------------------------------------------------------------
	// shadow of route and mask as written over the bus
	// ----------------------------------------------------------------
	logic [1:0] route_q;
	logic [1:0] mask_q;
	logic wr_acc;
	logic mapped;
	logic mode_a;
	logic st_rd;
	logic quiet;
	assign wr_acc = psel && penable && pready && pwrite;
	assign mode_a = paddr inside {MODE_BASE, MODE_BASE + 8'h04,
		MODE_BASE + 8'h08};
	assign mapped = mode_a || paddr inside {COUNT_BASE, COUNT_BASE + 8'h04,
		COUNT_BASE + 8'h08, CONFIG_OFFSET, STATUS_OFFSET, INT_MASK_OFFSET,
		OUT_STATE_OFFSET};
	assign st_rd = pready && !pwrite && paddr == STATUS_OFFSET;
	assign quiet = route_q == ROUTE_CASCADE || route_q == 2'h3;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			route_q <= ROUTE_RESET;
			mask_q <= MASK_RESET;
		end
		else if (wr_acc && paddr == CONFIG_OFFSET)
			route_q <= pwdata[1:0];
		else if (wr_acc && paddr == INT_MASK_OFFSET)
			mask_q <= pwdata[1:0];
	end
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_ready_zero_wait: assert property (psel && !penable |=> pready)
		else $error("no pready in access");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("pready held");
	a_err_unmapped: assert property (psel && !penable && !mapped
		|=> pslverr && prdata == 32'h0) else $error("unmapped accepted");
	a_err_mapped: assert property (psel && !penable && mapped
		|=> !pslverr) else $error("mapped refused");
	a_idle_quiet: assert property (!pready
		|-> prdata == 32'h0 && !pslverr) else $error("data while idle");
	a_irq_masked: assert property (irq |-> $past(mask_q) != 2'h0)
		else $error("irq while masked");
	a_cascade_quiet: assert property (quiet && $past(quiet)
		|-> !ext_out) else $error("ext_out in cascade");
	a_overrun_order: assert property (st_rd && prdata[STAT_OVERRUN]
		|-> prdata[STAT_COUNTUP]) else $error("overrun alone");
	a_mode_reads_zero: assert property (pready && !pwrite && mode_a
		|-> prdata == 32'h0) else $error("mode read not zero");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	c_irq: cover property ($rose(irq));
	c_err: cover property (pslverr);
	c_ext: cover property ($rose(ext_out));
endmodule // counter_sva
bind cascaded_interval_counter counter_sva counter_sva_i (.pclk, .presetn,
	.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.ext_clk, .ext_gate, .ext_out, .irq);
`default_nettype wire

//--- ext_partner.sv
`default_nettype none
module ext_partner #(
	parameter int PERIOD = 80
) (
	// control from the bench
	input wire logic run,
	input wire logic gate_level,
	input wire logic clear,
	// external io connector
	output logic ext_clk,
	output logic ext_gate,
	input wire logic ext_out,
	// observation
	output var int rises
);
	timeunit 1ns;
	timeprecision 1ps;
	// clock stands low between runs
	initial
	begin
		ext_clk = 1'b0;
		forever
		begin
			wait (run);
			#(PERIOD / 2 - 3) ext_clk = 1'b1;
			#(PERIOD / 2 + 3) ext_clk = 1'b0;
		end
	end
	assign ext_gate = gate_level;
	always @(posedge ext_out or posedge clear)
		if (clear)
			rises <= 0;
		else
			rises <= rises + 1;
endmodule // ext_partner
`default_nettype wire

//--- tb_cascaded_interval_counter.sv
`default_nettype none
module tb_cascaded_interval_counter import interval_counter_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int EXT_PER = 80;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic run = 1'b0;
	logic glev = 1'b0;
	logic clr = 1'b0;
	logic [31:0] prdata, q;
	logic pready, pslverr, ext_clk, ext_gate, ext_out, irq, err;
	logic [15:0] v;
	int rises;
	int num_errors = 0;
	int samples_checked = 0;
	time t0;
	cascaded_interval_counter cascaded_interval_counter_i (.pclk, .presetn,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .ext_clk, .ext_gate, .ext_out, .irq);
	ext_partner #(.PERIOD(EXT_PER)) ext_partner_i (.run(run),
		.gate_level(glev), .clear(clr), .ext_clk(ext_clk),
		.ext_gate(ext_gate), .ext_out(ext_out), .rises(rises));
	initial
	begin
		forever #4 pclk = ~pclk;
	end
	// ----------------------------------------------------------------
	// expectations
	// ----------------------------------------------------------------
	function automatic logic [31:0] cfg(input logic [1:0] r,
		input logic [2:0] g);
		return (32'(r) << ROUTE_LSB) | (32'(g) << GATE_LSB);
	endfunction
	function automatic logic [31:0] exp_status(input int n);
		return 32'({n > 1, n > 0});
	endfunction
	function automatic int per_tick(input int n);
		return n * int'(TICK_MOD) / int'(TICK_STEP);
	endfunction
	// ----------------------------------------------------------------
	// bus and checking tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic near(input int seen, input int exp, input int tol);
		check(32'(seen >= exp - tol && seen <= exp + tol), 32'h1);
	endtask
	task automatic results;
		$display("checked %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// only the watchdog ends a wait for pready
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic poll(input logic val);
		for (int i = 0; i < 60; i++)
		begin
			rd(OUT_STATE_OFFSET);
			if (q[0] === val)
				break;
		end
	endtask
	// settle, then count connector output rises over a span
	task automatic span(input int cyc);
		repeat (20) @(posedge pclk);
		clr <= 1'b1;
		@(posedge pclk);
		clr <= 1'b0;
		repeat (cyc) @(posedge pclk);
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		void'($urandom(32'h4532));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(CONFIG_OFFSET);
		check(q, cfg(ROUTE_RESET, GATE_RESET));
		rd(STATUS_OFFSET);
		check(q, exp_status(0));
		rd(INT_MASK_OFFSET);
		check(q, 32'(MASK_RESET));
		wr(8'h30, 32'h3);
		check(32'(err), 32'h1);
		for (int m = 0; m < 4; m++)
		begin
			wr(MODE_BASE, 32'(m));
			rd(OUT_STATE_OFFSET);
			check(q, 32'(m != 0));
			check(32'(err), 32'h0);
		end
		run <= 1'b1;
		glev <= 1'b1;
		for (int i = 0; i < 6; i++)
		begin
			v = 16'($urandom % 32'hffff) + 16'h1;
			wr(MODE_BASE, 32'(MODE_TC_EVENT));
			wr(COUNT_BASE, 32'(v));
			repeat (40) @(posedge pclk);
			rd(COUNT_BASE);
			check(q, 32'(v));
		end
		wr(MODE_BASE, 32'(MODE_ONE_SHOT));
		wr(COUNT_BASE, 32'h3);
		wr(CONFIG_OFFSET, cfg(ROUTE_CASCADE, 3'h1));
		poll(1'b0);
		t0 = $time;
		poll(1'b1);
		near(int'(($time - t0) / 8), per_tick(3), 8);
		wr(CONFIG_OFFSET, cfg(ROUTE_CASCADE, 3'h0));
		for (int c = 0; c < 3; c++)
		begin
			wr(MODE_BASE + 8'(4 * c), 32'(MODE_RATE));
			wr(COUNT_BASE + 8'(4 * c), 32'h2);
		end
		wr(CONFIG_OFFSET, cfg(ROUTE_CASCADE, 3'h7));
		repeat (1500) @(posedge pclk);
		check(32'(irq), 32'h0);
		rd(STATUS_OFFSET);
		check(q, exp_status(2));
		rd(STATUS_OFFSET);
		check(q, exp_status(0));
		wr(INT_MASK_OFFSET, 32'h1);
		for (int i = 0; i < 1000 && irq !== 1'b1; i++)
			@(posedge pclk);
		check(32'(irq), 32'h1);
		rd(STATUS_OFFSET);
		check(32'(q[STAT_COUNTUP]), 32'h1);
		repeat (3) @(posedge pclk);
		check(32'(irq), 32'h0);
		wr(CONFIG_OFFSET, cfg(ROUTE_EXT_FULL, 3'h0));
		span(400);
		near(rises, 400 * 8 / (EXT_PER * 4), 1);
		glev <= 1'b0;
		span(400);
		check(32'(rises), 32'h0);
		glev <= 1'b1;
		run <= 1'b0;
		span(400);
		check(32'(rises), 32'h0);
		wr(CONFIG_OFFSET, cfg(ROUTE_EXT_GATE, 3'h1));
		span(1000);
		near(rises, 1000 / per_tick(8), 1);
		glev <= 1'b0;
		span(1000);
		check(32'(rises), 32'h0);
		glev <= 1'b1;
		wr(CONFIG_OFFSET, cfg(ROUTE_EXT_GATE, 3'h0));
		span(1000);
		check(32'(rises), 32'h0);
		results();
	end
	initial
	begin
		repeat (30000) @(posedge pclk);
		num_errors++;
		results();
	end
endmodule // tb_cascaded_interval_counter
`default_nettype wire
